// *** nnt_pkg.sv ***
package nnt_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_ADDR_W = 12;
  localparam int PTR_W       = 21;
  localparam int WORD_ADDR_W = 20;

  // ----------------------------------------------------------------
  // instruction phases, one per mclk cycle
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // ----------------------------------------------------------------
  // opcodes and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] NEG_MASK   = 16'hfe00;
  localparam logic [15:0] NEG_CODE   = 16'h6c00;
  localparam logic [15:0] FETCH_MASK = 16'hfffc;
  localparam logic [15:0] FETCH_CODE = 16'h0008;
  localparam logic [15:0] NOP_ZERO   = 16'h0000;
  localparam logic [3:0]  NOP_NIBBLE = 4'hf;
  localparam int          BANK_BIT   = 8;

  localparam logic [1:0] MODE_KEEP    = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_POSTDEC = 2'h2;
  localparam logic [1:0] MODE_PREINC  = 2'h3;

  // ----------------------------------------------------------------
  // data memory addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_LOW_LAST = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK  = 4'hf;

  // ----------------------------------------------------------------
  // status flag positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;
  localparam logic [4:0]  STATUS_RESET = 5'h00;
  localparam logic [20:0] PTR_RESET    = 21'h000000;
  localparam logic [7:0]  LATCH_RESET  = 8'h00;

  typedef enum logic [1:0] {NNT_OP_NONE, NNT_OP_NEGATE, NNT_OP_FETCH} nnt_op_t;

  function automatic logic isNegate(input logic [15:0] w);
    return (w & NEG_MASK) == NEG_CODE;
  endfunction

  function automatic logic isFetch(input logic [15:0] w);
    return (w & FETCH_MASK) == FETCH_CODE;
  endfunction

  function automatic logic isNop(input logic [15:0] w);
    return (w == NOP_ZERO) || (w[15:12] == NOP_NIBBLE);
  endfunction

endpackage

// *** nnt_neg_if.sv ***
`timescale 1ns/1ps
interface nnt_neg_if;
  logic [7:0] operand;
  logic [7:0] result;
  logic [4:0] flags;

  modport alu  (input operand, output result, output flags);
  modport core (output operand, input result, input flags);
endinterface

// *** nnt_negate_unit.sv ***
`timescale 1ns/1ps
module nnt_negate_unit (
  nnt_neg_if.alu port
);

  // ----------------------------------------------------------------
  // two's complement and flags, seen as 0 - operand
  // ----------------------------------------------------------------
  always_comb begin
    port.result = 8'(~port.operand + 8'h01);
    port.flags                 = 5'h00;
    port.flags[nnt_pkg::FLAG_N]  = port.result[7];
    port.flags[nnt_pkg::FLAG_Z]  = (port.result == 8'h00);
    // only 80h overflows: its negation is itself
    port.flags[nnt_pkg::FLAG_OV] = (port.operand == 8'h80);
    // carry and nibble carry mean no borrow out of the subtraction
    port.flags[nnt_pkg::FLAG_C]  = (port.operand == 8'h00);
    port.flags[nnt_pkg::FLAG_DC] = (port.operand[3:0] == 4'h0);
  end

endmodule

// *** nnt_exec.sv ***
`timescale 1ns/1ps
// Contract
// - negate is invert plus one
// - result written back to operand location
// - bank bit zero uses access bank
// - bank bit one uses bank select register
// - extended set, low addresses use indexed offset
// - negate sets N, OV, C, DC, Z
// - fetch copies program byte into latch
// - mode keeps, post-increments, post-decrements, pre-increments
// - pointer is 21-bit byte address
// - pointer bit zero picks low/high byte
// - fetch takes two cycles, read Q2
// - latch written in second cycle Q4
module nnt_exec (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  output logic             instrReady,
  input  wire logic        extendedSetEn,
  input  wire logic [3:0]  bankSelectReg,
  input  wire logic [11:0] indexBase,
  output logic [11:0]      dataAddr,
  output logic             dataRdEn,
  input  wire logic [7:0]  dataRdData,
  output logic             dataWrEn,
  output logic [7:0]       dataWrData,
  output logic [19:0]      progAddr,
  output logic             progRdEn,
  input  wire logic [15:0] progRdData,
  input  wire logic        pointerLoad,
  input  wire logic [20:0] pointerLoadValue,
  output logic [20:0]      programBytePointer,
  output logic [7:0]       fetchedByteLatch,
  output logic [4:0]       statusFlags,
  output logic [1:0]       qPhase
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       phase;
    nnt_pkg::nnt_op_t op;
    logic             second;
    logic [1:0]       mode;
    logic [11:0]      addr;
    logic [7:0]       operand;
    logic [7:0]       result;
    logic [4:0]       status;
    logic [20:0]      ptr;
    logic [15:0]      progWord;
    logic [7:0]       latch;
  } nnt_state_t;

  nnt_state_t st;
  nnt_state_t next_st;
  nnt_neg_if  negBus ();
  logic       accept;

  nnt_negate_unit negUnit (
    .port (negBus.alu)
  );

  assign negBus.operand = st.operand;

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  function automatic logic [11:0] resolveAddr(input logic [15:0] w,
                                              input logic        ext,
                                              input logic [3:0]  bank_select_reg,
                                              input logic [11:0] base);
    logic [7:0] f;
    f = w[7:0];
    if (w[nnt_pkg::BANK_BIT]) begin
      resolveAddr = {bank_select_reg, f};
    end else if (ext && (f <= nnt_pkg::ACCESS_LOW_LAST)) begin
      resolveAddr = 12'(base + {4'h0, f});
    end else if (f <= nnt_pkg::ACCESS_LOW_LAST) begin
      resolveAddr = {nnt_pkg::ACCESS_LOW_BANK, f};
    end else begin
      resolveAddr = {nnt_pkg::ACCESS_HI_BANK, f};
    end
  endfunction

  // ----------------------------------------------------------------
  // handshake and strobes
  // ----------------------------------------------------------------
  // a fetch blocks the decoder for its whole second cycle
  assign instrReady = (st.phase == nnt_pkg::PH_Q1) && !st.second;
  assign accept     = instrReady && instrValid;
  assign dataRdEn   = (st.op == nnt_pkg::NNT_OP_NEGATE) && (st.phase == nnt_pkg::PH_Q2);
  assign dataWrEn   = (st.op == nnt_pkg::NNT_OP_NEGATE) && (st.phase == nnt_pkg::PH_Q4);
  assign progRdEn   = (st.op == nnt_pkg::NNT_OP_FETCH) && st.second
                      && (st.phase == nnt_pkg::PH_Q2);

  assign dataAddr           = st.addr;
  assign dataWrData         = st.result;
  assign progAddr           = st.ptr[20:1];
  assign programBytePointer = st.ptr;
  assign fetchedByteLatch   = st.latch;
  assign statusFlags        = st.status;
  assign qPhase             = st.phase;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.phase = 2'(st.phase + 2'h1);
    // pointer writes are held off while a fetch owns the pointer
    if (pointerLoad && (st.op == nnt_pkg::NNT_OP_NONE) && !accept) begin
      next_st.ptr = pointerLoadValue;
    end
    if (accept) begin
      // nop and unknown words leave every register alone
      if (nnt_pkg::isNegate(instrWord)) begin
        next_st.op   = nnt_pkg::NNT_OP_NEGATE;
        next_st.addr = resolveAddr(instrWord, extendedSetEn, bankSelectReg, indexBase);
      end else if (nnt_pkg::isFetch(instrWord)) begin
        next_st.op     = nnt_pkg::NNT_OP_FETCH;
        next_st.mode   = instrWord[1:0];
        next_st.second = 1'b0;
      end
    end
    case (st.op)
      nnt_pkg::NNT_OP_NEGATE: begin
        case (st.phase)
          nnt_pkg::PH_Q2: begin
            next_st.operand = dataRdData;
          end
          nnt_pkg::PH_Q3: begin
            next_st.result = negBus.result;
            next_st.status = negBus.flags;
          end
          nnt_pkg::PH_Q4: begin
            next_st.op = nnt_pkg::NNT_OP_NONE;
          end
          default: begin
          end
        endcase
      end
      nnt_pkg::NNT_OP_FETCH: begin
        if (!st.second) begin
          if (st.phase == nnt_pkg::PH_Q4) begin
            next_st.second = 1'b1;
          end
        end else begin
          case (st.phase)
            nnt_pkg::PH_Q1: begin
              if (st.mode == nnt_pkg::MODE_PREINC) begin
                next_st.ptr = 21'(st.ptr + 21'h000001);
              end
            end
            nnt_pkg::PH_Q2: begin
              next_st.progWord = progRdData;
            end
            nnt_pkg::PH_Q4: begin
              next_st.latch = st.ptr[0] ? st.progWord[15:8]
                                        : st.progWord[7:0];
              if (st.mode == nnt_pkg::MODE_POSTINC) begin
                next_st.ptr = 21'(st.ptr + 21'h000001);
              end else if (st.mode == nnt_pkg::MODE_POSTDEC) begin
                next_st.ptr = 21'(st.ptr - 21'h000001);
              end
              next_st.op     = nnt_pkg::NNT_OP_NONE;
              next_st.second = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st          <= '0;
      st.op       <= nnt_pkg::NNT_OP_NONE;
      st.phase    <= nnt_pkg::PH_Q1;
      st.status   <= nnt_pkg::STATUS_RESET;
      st.ptr      <= nnt_pkg::PTR_RESET;
      st.latch    <= nnt_pkg::LATCH_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic acceptNeg;
  logic acceptFetch;
  logic acceptNop;
  assign acceptNeg   = accept && nnt_pkg::isNegate(instrWord);
  assign acceptFetch = accept && nnt_pkg::isFetch(instrWord);
  assign acceptNop   = accept && nnt_pkg::isNop(instrWord);

  sequence negSteps;
    dataRdEn ##2 dataWrEn;
  endsequence

  // first cycle is four quiet phases, the read lands in Q2 of the second
  sequence fetchWait;
    !progRdEn [*5] ##1 progRdEn;
  endsequence

  // decoder is held off for the whole second cycle, then freed
  sequence fetchHold;
    !instrReady [*4] ##1 instrReady;
  endsequence

  negate_cycle_a: assert property (acceptNeg |=> negSteps)
    else $error("negate read/write not in Q2/Q4");

  negate_value_a: assert property (dataRdEn |-> ##2
      (dataWrData == 8'(~$past(dataRdData, 2) + 8'h01)))
    else $error("negate result wrong");

  same_location_a: assert property (dataRdEn |-> ##2
      (dataWrEn && dataAddr == $past(dataAddr, 2)))
    else $error("write-back address differs from read");

  access_bank_a: assert property (
      (acceptNeg && !instrWord[8] && !extendedSetEn) |=>
      (dataAddr == (($past(instrWord[7:0]) <= 8'h5f) ? {4'h0, $past(instrWord[7:0])}
                                                  : {4'hf, $past(instrWord[7:0])})))
    else $error("access bank address wrong");

  bank_select_a: assert property ((acceptNeg && instrWord[8]) |=>
      (dataAddr == {$past(bankSelectReg), $past(instrWord[7:0])}))
    else $error("banked address wrong");

  indexed_offset_a: assert property ((acceptNeg && !instrWord[8] && extendedSetEn
      && instrWord[7:0] <= 8'h5f) |=>
      (dataAddr == 12'($past(indexBase) + {4'h0, $past(instrWord[7:0])})))
    else $error("indexed offset address wrong");

  negate_flags_a: assert property (dataWrEn |->
      (statusFlags[4] == dataWrData[7]) && (statusFlags[2] == (dataWrData == 8'h00))
      && (statusFlags[0] == (dataWrData == 8'h00)))
    else $error("negate flags disagree with result");

  // only 80h negates to 80h, and a zero low nibble survives negation
  negate_ovdc_a: assert property (dataWrEn |->
      (statusFlags[3] == (dataWrData == 8'h80))
      && (statusFlags[1] == (dataWrData[3:0] == 4'h0)))
    else $error("overflow or nibble carry wrong");

  fetch_timing_a: assert property (acceptFetch |-> fetchWait)
    else $error("program read not in Q2 of second cycle");

  fetch_hold_a: assert property (acceptFetch |-> ##4 fetchHold)
    else $error("decoder not held for the second fetch cycle");

  fetch_quiet_a: assert property (acceptFetch |=>
      (!dataRdEn && !dataWrEn && $stable(statusFlags)) [*7])
    else $error("fetch touched data memory or flags");

  latch_byte_a: assert property (progRdEn |-> ##3 (fetchedByteLatch ==
      ($past(programBytePointer[0], 3) ? $past(progRdData[15:8], 3)
                                       : $past(progRdData[7:0], 3))))
    else $error("latch not loaded with selected byte");

  keep_ptr_a: assert property ((acceptFetch && instrWord[1:0] == 2'h0) |-> ##8
      (programBytePointer == $past(programBytePointer, 8)))
    else $error("pointer moved in keep mode");

  post_inc_a: assert property ((acceptFetch && instrWord[1:0] == 2'h1) |-> ##8
      (programBytePointer == 21'($past(programBytePointer, 8) + 21'h000001)))
    else $error("post-increment wrong");

  post_dec_a: assert property ((acceptFetch && instrWord[1:0] == 2'h2) |-> ##8
      (programBytePointer == 21'($past(programBytePointer, 8) - 21'h000001)))
    else $error("post-decrement wrong");

  pre_inc_a: assert property ((acceptFetch && instrWord[1:0] == 2'h3) |-> ##5
      (progRdEn && programBytePointer == 21'($past(programBytePointer, 5) + 21'h000001)))
    else $error("pre-increment not before read");

  nop_quiet_a: assert property (acceptNop |=> (!dataWrEn && !progRdEn
      && $stable(statusFlags) && $stable(fetchedByteLatch)) [*3])
    else $error("no-operation changed state");

  nop_one_cycle_a: assert property (acceptNop |-> ##4 instrReady)
    else $error("no-operation took more than one cycle");

endmodule

// *** nnt_mem_model.sv ***
`timescale 1ns/1ps
module nnt_mem_model (
  input  wire logic        mclk,
  input  wire logic [11:0] dataAddr,
  input  wire logic        dataRdEn,
  output logic      [7:0]  dataRdData,
  input  wire logic        dataWrEn,
  input  wire logic [7:0]  dataWrData,
  input  wire logic [19:0] progAddr,
  input  wire logic        progRdEn,
  output logic      [15:0] progRdData
);
  // ----
  // data and program memory
  // ----
  logic [7:0]  dataMem [4096];
  logic [15:0] junk = 16'h1234;

  // junk moves every cycle so a read sampled off its strobe never looks right
  always @(posedge mclk) begin
    junk <= ~junk + 16'h1;
    if (dataWrEn) begin
      dataMem[dataAddr] <= dataWrData;
    end
  end

  assign dataRdData = dataRdEn ? dataMem[dataAddr] : junk[7:0];
  // program word is a pure function of its address, so no array is needed
  assign progRdData = progRdEn ? {progAddr[7:0] + 8'h3c, progAddr[15:8] ^ progAddr[7:0]} : junk;
endmodule

// *** negate_nop_table_read_exec_tb_top.sv ***
`timescale 1ns/1ps
module negate_nop_table_read_exec_tb_top;
  logic        mclk, rst_b, instrValid, instrReady, extendedSetEn, pointerLoad;
  logic        dataRdEn, dataWrEn, progRdEn;
  logic [15:0] instrWord, progRdData;
  logic [3:0]  bankSelectReg;
  logic [11:0] indexBase, dataAddr;
  logic [7:0]  dataRdData, dataWrData, fetchedByteLatch;
  logic [19:0] progAddr;
  logic [20:0] pointerLoadValue, programBytePointer;
  logic [4:0]  statusFlags;
  logic [1:0]  qPhase;
  logic [31:0] seed = 32'h743d5319;
  logic [31:0] r;
  int          num_errors = 0;
  int          tests_run = 0;

  nnt_exec i_nnt_exec (.mclk(mclk), .rst_b(rst_b), .instrWord(instrWord),
    .instrValid(instrValid), .instrReady(instrReady), .extendedSetEn(extendedSetEn),
    .bankSelectReg(bankSelectReg), .indexBase(indexBase), .dataAddr(dataAddr),
    .dataRdEn(dataRdEn), .dataRdData(dataRdData), .dataWrEn(dataWrEn),
    .dataWrData(dataWrData), .progAddr(progAddr), .progRdEn(progRdEn),
    .progRdData(progRdData), .pointerLoad(pointerLoad), .pointerLoadValue(pointerLoadValue),
    .programBytePointer(programBytePointer), .fetchedByteLatch(fetchedByteLatch),
    .statusFlags(statusFlags), .qPhase(qPhase));

  nnt_mem_model i_nnt_mem_model (.mclk(mclk), .dataAddr(dataAddr), .dataRdEn(dataRdEn),
    .dataRdData(dataRdData), .dataWrEn(dataWrEn), .dataWrData(dataWrData),
    .progAddr(progAddr), .progRdEn(progRdEn), .progRdData(progRdData));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // returns at the falling edge of the cycle after acceptance
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    while (!(qPhase === 2'h0 && instrReady === 1'b1) && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) check(0, 1, "never ready");
    instrWord = w;
    instrValid = 1'b1;
    @(negedge mclk);
    instrValid = 1'b0;
  endtask

  task automatic negTest(input logic [7:0] f, input logic a, input logic e, input logic [7:0] op);
    logic [11:0] addr;
    logic [7:0]  res;
    r = rnd();
    bankSelectReg = r[3:0];
    indexBase = r[15:4];
    extendedSetEn = e;
    if (a) addr = {bankSelectReg, f};
    else if (e && f <= 8'h5f) addr = indexBase + {4'h0, f};
    else addr = {(f <= 8'h5f) ? 4'h0 : 4'hf, f};
    res = ~op + 8'h1;
    i_nnt_mem_model.dataMem[addr] = op;
    issue(16'h6c00 | {7'h0, a, f});
    check(dataRdEn, 1, "read strobe");
    check(qPhase, 2'h1, "read in Q2");
    check(dataAddr, addr, "operand address");
    repeat (2) @(negedge mclk);
    check(dataWrEn, 1, "write strobe");
    @(negedge mclk);
    check(i_nnt_mem_model.dataMem[addr], res, "negated byte");
    check(statusFlags, {res[7], op == 8'h80, res == 8'h0, op[3:0] == 4'h0, op == 8'h0},
          "flags");
  endtask

  task automatic fetchTest(input logic [20:0] ptr, input logic [1:0] mode);
    logic [20:0] p;
    logic [15:0] w;
    logic [7:0]  old;
    pointerLoadValue = ptr;
    pointerLoad = 1'b1;
    @(negedge mclk);
    pointerLoad = 1'b0;
    check(programBytePointer, ptr, "pointer load");
    p = (mode == 2'h3) ? ptr + 21'h1 : ptr;
    w = {p[8:1] + 8'h3c, p[16:9] ^ p[8:1]};
    old = fetchedByteLatch;
    issue(16'h0008 | {14'h0, mode});
    repeat (4) @(negedge mclk);
    check(progRdEn, 1, "program read strobe");
    check(progAddr, p[20:1], "program address");
    repeat (2) @(negedge mclk);
    check(fetchedByteLatch, old, "latch early");
    @(negedge mclk);
    check(fetchedByteLatch, p[0] ? w[15:8] : w[7:0], "latch");
    if (mode == 2'h1) p = p + 21'h1;
    if (mode == 2'h2) p = p - 21'h1;
    check(programBytePointer, p, "pointer after");
  endtask

  task automatic nopTest(input logic [15:0] w);
    logic [20:0] p;
    logic [12:0] s;
    p = programBytePointer;
    s = {fetchedByteLatch, statusFlags};
    issue(w);
    repeat (3) begin
      check({dataWrEn, progRdEn, dataRdEn}, 0, "nop strobes");
      @(negedge mclk);
    end
    check(instrReady, 1, "nop one cycle");
    check(programBytePointer, p, "nop pointer");
    check({fetchedByteLatch, statusFlags}, s, "nop state");
  endtask

  // ----
  // clock, watchdog, sequence
  // ----
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // roughly 600 cycles are needed; allow about eight times that
  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    instrValid = 1'b0;
    instrWord = 16'h0;
    extendedSetEn = 1'b0;
    bankSelectReg = 4'h0;
    indexBase = 12'h0;
    pointerLoad = 1'b0;
    pointerLoadValue = 21'h0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check({programBytePointer, fetchedByteLatch}, 0, "reset state");
    rst_b = 1'b1;
    negTest(8'h5f, 1'b0, 1'b1, 8'h00);
    negTest(8'h60, 1'b0, 1'b1, 8'h80);
    negTest(8'h5f, 1'b0, 1'b0, 8'h3a);
    negTest(8'h60, 1'b0, 1'b0, 8'hf0);
    negTest(8'hff, 1'b1, 1'b1, 8'h01);
    repeat (40) begin
      r = rnd();
      negTest(r[7:0], r[8], r[9], r[23:16]);
    end
    $display("negate tests done");
    for (int m = 0; m < 4; m++) begin
      fetchTest(21'h1fffff, m[1:0]);
      fetchTest(21'h000000, m[1:0]);
    end
    repeat (24) begin
      r = rnd();
      fetchTest(r[20:0], r[22:21]);
    end
    $display("fetch tests done");
    nopTest(16'h0000);
    repeat (8) begin
      r = rnd();
      nopTest({4'hf, r[11:0]});
    end
    $display("nop tests done");
    wrap_up();
  end
endmodule
